// ===== hdl/ef_stage_defs.vh
// Purpose: Constants for the earth fault stage indication block
// Assumes: 50 MHz sys_clk, AXI4-Lite register access
// Notes: Contract list below
//
// Contract
// - Asserted block input inhibits its own stage, low or high.
// - Remote selection on: select 0 gives sine, 1 gives cosine characteristic.
// - Trip only if start persists for the stage operate time.
// - Indicator yellow while started, red once tripped.
// - Each of four indications is self-reset or manual-reset by mode switches.
// - Manual start, self-reset trip: red on trip, yellow remains afterwards.
// - Manual indications clear on reset button or either remote reset command.
// - Unreset indications never affect starting or tripping.
// - Shortly after permanent fault: fault lamp and supervision relay together.
// - Display shows a fault code identifying the fault type.
// - Fault code: red leading one plus three green digits, reset-proof.
// - Settings on three right digits, knob LED marks shown setting.
// - Low stage start current 1 to 10 percent.
// - Low operate time 0.1-1.0 s, or 1.0-10.0 s with switch five.
// - High start 5-40 percent, or 1-8 percent with switch six.
// - Infinite high start setting takes high stage out of function.
// - Reverse high stage shows setting negative with red minus sign.
// - High stage operate time 0.1 to 1.0 s.
// - Switch group LED lit: display checksum of switch positions.
// - Two reclose start-initiation outputs besides stage start and trip outputs.
// - Routing switches gate blocking inputs and routed start outputs.
`ifndef EF_STAGE_DEFS_VH
`define EF_STAGE_DEFS_VH

// ==========================================
// Register offsets
`define OFS_SWITCH 8'h00
`define OFS_LOW_SET 8'h04
`define OFS_HIGH_SET 8'h08
`define OFS_DISP_SEL 8'h0c
`define OFS_RESET_CMD 8'h10
`define OFS_STATUS 8'h14
`define OFS_DISPLAY 8'h18

// ==========================================
// Reset values
`define RST_SWITCH 32'h00000000
`define RST_LOW_SET 32'h00000101
`define RST_HIGH_SET 32'h00000105

// ==========================================
// Front switch positions
`define SW_REVERSE 0
`define SW_REMOTE 1
`define SW_LOCAL_COS 2
`define SW_LATCH 3
`define SW_LONG_TIME 4
`define SW_HIGH_LOW_RANGE 5

// ==========================================
// Setting limits
`define LOW_START_MIN 8'h01
`define LOW_START_MAX 8'h0a
`define LOW_TIME_MIN 8'h01
`define LOW_TIME_MAX 8'h0a
`define LOW_TIME_LMIN 8'h0a
`define LOW_TIME_LMAX 8'h64
`define HIGH_START_MIN 8'h05
`define HIGH_START_MAX 8'h28
`define HIGH_START_LMIN 8'h01
`define HIGH_START_LMAX 8'h08
`define HIGH_START_INF 8'hff
`define HIGH_TIME_MIN 8'h01
`define HIGH_TIME_MAX 8'h0a

// ==========================================
// Display selection codes
`define DSP_LOW_START 3'h0
`define DSP_LOW_TIME 3'h1
`define DSP_HIGH_START 3'h2
`define DSP_HIGH_TIME 3'h3
`define DSP_CHECKSUM 3'h4

// ==========================================
// Timing
`define TIME_STEP_MS 100
`define CLK_MHZ 50
`define TICK_CYCLES (`TIME_STEP_MS * 1000 * `CLK_MHZ)
`define FAULT_CONFIRM_CYCLES 8'h10

`endif

// ===== hdl/stage_timer.v
// Purpose: Definite time operate timer of one protection stage
// Assumes: tick is a one-cycle pulse each 0.1 s
// Notes: Output latch held until clear
`timescale 1ns/1ns
module stage_timer #(
	parameter CNT_W = 8
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst_b,
	// Timing
	input wire tick,
	input wire [CNT_W-1:0] time_set,
	// Stage control
	input wire start,
	input wire latch_en,
	input wire clear,
	output reg trip_reg
);

// ==========================================
// Operate time counter
reg [CNT_W-1:0] count_reg;
reg [CNT_W-1:0] count_next;
reg trip_next;

always @* begin
	count_next = count_reg;
	trip_next = trip_reg;
	if (!start) begin
		count_next = {CNT_W{1'b0}};
		if (!latch_en || clear)
			trip_next = 1'b0;
	end else begin
		if (tick && count_reg <= time_set)
			count_next = count_reg + 1'b1;
		if (count_reg > time_set)
			trip_next = 1'b1;
		else if (clear)
			trip_next = 1'b0;
	end
end

always @(posedge sys_clk) begin
	if (!rst_b) begin
		count_reg <= {CNT_W{1'b0}};
		trip_reg <= 1'b0;
	end else begin
		count_reg <= count_next;
		trip_reg <= trip_next;
	end
end

endmodule

// ===== hdl/earth_fault_stage_indication.v
// Purpose: Stage start, trip, indication, blocking and display logic
// Assumes: Measured components arrive in whole percent of rated current
// Notes: Registers over AXI4-Lite, operate times in 0.1 s steps
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "ef_stage_defs.vh"
module earth_fault_stage_indication #(
	parameter TICK_CYCLES = `TICK_CYCLES
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst_b,
	// AXI4-Lite write
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Measurement
	input wire [7:0] level_sin,
	input wire [7:0] level_cos,
	input wire voltage_above,
	input wire direction_reverse,
	// External controls
	input wire low_stage_block,
	input wire high_stage_block,
	input wire characteristic_select,
	input wire reset_button,
	// Self-supervision
	input wire internal_fault,
	input wire [11:0] fault_code,
	// Stage outputs
	output reg low_stage_start_out,
	output wire low_stage_trip_out,
	output reg high_stage_start_out,
	output wire high_stage_trip_out,
	output reg reclose_initiate_a,
	output reg reclose_initiate_b,
	// Indicators
	output reg [1:0] lamp_yellow,
	output reg [1:0] lamp_red,
	output reg self_fault_lamp,
	output reg supervision_relay,
	// Display
	output reg disp_red_one,
	output reg disp_red_minus,
	output reg [11:0] disp_digits,
	output reg [4:0] setting_leds
);

// ==========================================
// Helpers
function [7:0] clamp;
	input [7:0] v;
	input [7:0] lo;
	input [7:0] hi;
	begin
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	end
endfunction

function [11:0] to_bcd;
	input [7:0] v;
	reg [19:0] s;
	integer i;
	begin
		s = {12'h000, v};
		for (i = 0; i < 8; i = i + 1) begin
			if (s[11:8] > 4'h4)
				s[11:8] = s[11:8] + 4'h3;
			if (s[15:12] > 4'h4)
				s[15:12] = s[15:12] + 4'h3;
			if (s[19:16] > 4'h4)
				s[19:16] = s[19:16] + 4'h3;
			s = {s[18:0], 1'b0};
		end
		to_bcd = s[19:8];
	end
endfunction

// ==========================================
// Registers
reg [31:0] switch_reg;
reg [31:0] low_set_reg;
reg [31:0] high_set_reg;
reg [2:0] disp_sel_reg;
reg clear_pulse_reg;

wire [7:0] front_switch_group = switch_reg[7:0];
wire [3:0] indicator_mode_switches = switch_reg[11:8];
wire [3:0] board_routing_switches = switch_reg[19:16];

// ==========================================
// AXI4-Lite slave
reg aw_held_reg;
reg w_held_reg;
reg [7:0] aw_addr_reg;
reg [31:0] w_data_reg;
reg [3:0] w_strb_reg;
wire aw_take = s_axi_awvalid && s_axi_awready;
wire w_take = s_axi_wvalid && s_axi_wready;
wire [7:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
wire [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
wire [3:0] wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
wire wr_fire = (aw_held_reg || aw_take) && (w_held_reg || w_take) && !s_axi_bvalid;
wire wr_known = wr_addr == `OFS_SWITCH || wr_addr == `OFS_LOW_SET || wr_addr == `OFS_HIGH_SET ||
	wr_addr == `OFS_DISP_SEL || wr_addr == `OFS_RESET_CMD;

assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;

function [31:0] merge;
	input [31:0] old;
	input [31:0] d;
	input [3:0] be;
	integer k;
	begin
		merge = old;
		for (k = 0; k < 4; k = k + 1)
			if (be[k])
				merge[k*8 +: 8] = d[k*8 +: 8];
	end
endfunction

always @(posedge sys_clk) begin
	if (!rst_b) begin
		aw_held_reg <= 1'b0;
		w_held_reg <= 1'b0;
		aw_addr_reg <= 8'h00;
		w_data_reg <= 32'h00000000;
		w_strb_reg <= 4'h0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= 2'h0;
		switch_reg <= `RST_SWITCH;
		low_set_reg <= `RST_LOW_SET;
		high_set_reg <= `RST_HIGH_SET;
		disp_sel_reg <= `DSP_LOW_START;
		clear_pulse_reg <= 1'b0;
	end else begin
		clear_pulse_reg <= 1'b0;
		if (s_axi_bvalid && s_axi_bready)
			s_axi_bvalid <= 1'b0;
		if (wr_fire) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_known ? 2'h0 : 2'h2;
			case (wr_addr)
				`OFS_SWITCH: switch_reg <= merge(switch_reg, wr_data, wr_strb) & 32'h000f0fff;
				`OFS_LOW_SET: low_set_reg <= merge(low_set_reg, wr_data, wr_strb) & 32'h0000ffff;
				`OFS_HIGH_SET: high_set_reg <= merge(high_set_reg, wr_data, wr_strb) & 32'h0000ffff;
				`OFS_DISP_SEL: begin
					if (wr_strb[0])
						disp_sel_reg <= wr_data[2:0];
				end
				`OFS_RESET_CMD: begin
					if (wr_strb[0] && wr_data[1:0] != 2'h0)
						clear_pulse_reg <= 1'b1;
				end
				default: begin
				end
			endcase
		end else begin
			if (aw_take) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (w_take) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
		end
	end
end

// ==========================================
// Effective settings
reg [7:0] low_start_eff;
reg [7:0] low_time_eff;
reg [7:0] high_start_eff;
reg [7:0] high_time_eff;
reg high_off;

always @* begin
	low_start_eff = clamp(low_set_reg[7:0], `LOW_START_MIN, `LOW_START_MAX);
	if (front_switch_group[`SW_LONG_TIME])
		low_time_eff = clamp(low_set_reg[15:8], `LOW_TIME_LMIN, `LOW_TIME_LMAX);
	else
		low_time_eff = clamp(low_set_reg[15:8], `LOW_TIME_MIN, `LOW_TIME_MAX);
	high_off = high_set_reg[7:0] == `HIGH_START_INF;
	if (front_switch_group[`SW_HIGH_LOW_RANGE])
		high_start_eff = clamp(high_set_reg[7:0], `HIGH_START_LMIN, `HIGH_START_LMAX);
	else
		high_start_eff = clamp(high_set_reg[7:0], `HIGH_START_MIN, `HIGH_START_MAX);
	high_time_eff = clamp(high_set_reg[15:8], `HIGH_TIME_MIN, `HIGH_TIME_MAX);
end

// ==========================================
// Time base
reg [31:0] tick_cnt_reg;
reg tick_reg;

always @(posedge sys_clk) begin
	if (!rst_b) begin
		tick_cnt_reg <= 32'h00000000;
		tick_reg <= 1'b0;
	end else if (tick_cnt_reg >= TICK_CYCLES - 1) begin
		tick_cnt_reg <= 32'h00000000;
		tick_reg <= 1'b1;
	end else begin
		tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
		tick_reg <= 1'b0;
	end
end

// ==========================================
// Stage start conditions
wire use_cos = front_switch_group[`SW_REMOTE] ? characteristic_select :
	front_switch_group[`SW_LOCAL_COS];
wire [7:0] level = use_cos ? level_cos : level_sin;
wire low_blk = board_routing_switches[0] && low_stage_block;
wire high_blk = board_routing_switches[1] && high_stage_block;
wire high_dir_ok = front_switch_group[`SW_REVERSE] ? direction_reverse : !direction_reverse;
wire low_start = voltage_above && !direction_reverse && level >= low_start_eff && !low_blk;
wire high_start = voltage_above && high_dir_ok && !high_off && level >= high_start_eff && !high_blk;
wire any_clear = clear_pulse_reg || reset_button;
wire low_trip;
wire high_trip;

stage_timer #(
	.CNT_W(8)
) low_timer (
	.sys_clk(sys_clk),
	.rst_b(rst_b),
	.tick(tick_reg),
	.time_set(low_time_eff),
	.start(low_start),
	.latch_en(front_switch_group[`SW_LATCH]),
	.clear(any_clear),
	.trip_reg(low_trip)
);

stage_timer #(
	.CNT_W(8)
) high_timer (
	.sys_clk(sys_clk),
	.rst_b(rst_b),
	.tick(tick_reg),
	.time_set(high_time_eff),
	.start(high_start),
	.latch_en(front_switch_group[`SW_LATCH]),
	.clear(any_clear),
	.trip_reg(high_trip)
);

assign low_stage_trip_out = low_trip;
assign high_stage_trip_out = high_trip;

always @(posedge sys_clk) begin
	if (!rst_b) begin
		low_stage_start_out <= 1'b0;
		high_stage_start_out <= 1'b0;
		reclose_initiate_a <= 1'b0;
		reclose_initiate_b <= 1'b0;
	end else begin
		low_stage_start_out <= low_start;
		high_stage_start_out <= high_start;
		reclose_initiate_a <= board_routing_switches[2] && low_start;
		reclose_initiate_b <= board_routing_switches[3] && high_start;
	end
end

// ==========================================
// Operation indicators
wire [3:0] live_cond = {high_trip, high_start, low_trip, low_start};
reg [3:0] ind_reg;
genvar g;

generate
	for (g = 0; g < 4; g = g + 1) begin : ind_gen
		always @(posedge sys_clk) begin
			if (!rst_b)
				ind_reg[g] <= 1'b0;
			else if (live_cond[g])
				ind_reg[g] <= 1'b1;
			else if (!indicator_mode_switches[g] || any_clear)
				ind_reg[g] <= 1'b0;
		end
	end
endgenerate

always @(posedge sys_clk) begin
	if (!rst_b) begin
		lamp_yellow <= 2'h0;
		lamp_red <= 2'h0;
	end else begin
		lamp_red <= {ind_reg[3], ind_reg[1]};
		lamp_yellow <= {ind_reg[2] && !ind_reg[3], ind_reg[0] && !ind_reg[1]};
	end
end

// ==========================================
// Self-supervision
reg [7:0] fault_cnt_reg;
reg fault_seen_reg;

always @(posedge sys_clk) begin
	if (!rst_b) begin
		fault_cnt_reg <= 8'h00;
		self_fault_lamp <= 1'b0;
		supervision_relay <= 1'b0;
		fault_seen_reg <= 1'b0;
	end else if (!internal_fault) begin
		fault_cnt_reg <= 8'h00;
	end else if (fault_cnt_reg < `FAULT_CONFIRM_CYCLES) begin
		fault_cnt_reg <= fault_cnt_reg + 8'h01;
	end else begin
		self_fault_lamp <= 1'b1;
		supervision_relay <= 1'b1;
		fault_seen_reg <= fault_code != 12'h000;
	end
end

// ==========================================
// Display
always @(posedge sys_clk) begin
	if (!rst_b) begin
		disp_red_one <= 1'b0;
		disp_red_minus <= 1'b0;
		disp_digits <= 12'h000;
		setting_leds <= 5'h00;
	end else if (fault_seen_reg) begin
		disp_red_one <= 1'b1;
		disp_red_minus <= 1'b0;
		disp_digits <= fault_code;
		setting_leds <= 5'h00;
	end else begin
		disp_red_one <= 1'b0;
		disp_red_minus <= 1'b0;
		setting_leds <= 5'h00;
		case (disp_sel_reg)
			`DSP_LOW_START: begin
				disp_digits <= to_bcd(low_start_eff);
				setting_leds[0] <= 1'b1;
			end
			`DSP_LOW_TIME: begin
				disp_digits <= to_bcd(low_time_eff);
				setting_leds[1] <= 1'b1;
			end
			`DSP_HIGH_START: begin
				disp_digits <= high_off ? 12'hfff : to_bcd(high_start_eff);
				disp_red_minus <= front_switch_group[`SW_REVERSE];
				setting_leds[2] <= 1'b1;
			end
			`DSP_HIGH_TIME: begin
				disp_digits <= to_bcd(high_time_eff);
				setting_leds[3] <= 1'b1;
			end
			default: begin
				disp_digits <= to_bcd(front_switch_group);
				setting_leds[4] <= 1'b1;
			end
		endcase
	end
end

// ==========================================
// Register read
always @(posedge sys_clk) begin
	if (!rst_b) begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= 2'h0;
	end else if (s_axi_rvalid) begin
		if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end else if (s_axi_arvalid) begin
		s_axi_rvalid <= 1'b1;
		s_axi_rresp <= 2'h0;
		case (s_axi_araddr)
			`OFS_SWITCH: s_axi_rdata <= switch_reg;
			`OFS_LOW_SET: s_axi_rdata <= low_set_reg;
			`OFS_HIGH_SET: s_axi_rdata <= high_set_reg;
			`OFS_DISP_SEL: s_axi_rdata <= {29'h00000000, disp_sel_reg};
			`OFS_RESET_CMD: s_axi_rdata <= 32'h00000000;
			`OFS_STATUS: s_axi_rdata <= {18'h00000, supervision_relay, self_fault_lamp, lamp_red, lamp_yellow,
				ind_reg, high_trip, high_start, low_trip, low_start};
			`OFS_DISPLAY: s_axi_rdata <= {13'h0000, disp_red_one, disp_red_minus, setting_leds, disp_digits};
			default: begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= 2'h2;
			end
		endcase
	end
end

endmodule

// ===== verification/ef_stage_monitor.sv
// Purpose: Port checker for the stage indication block
// Assumes: Sees only top-level ports
// Notes: Attached by bind
`timescale 1ns/1ns
module ef_stage_monitor (
	// Clock and reset
	input wire sys_clk,
	input wire rst_b,
	// Observed
	input wire internal_fault,
	input wire reset_button,
	input wire low_stage_start_out,
	input wire low_stage_trip_out,
	input wire high_stage_start_out,
	input wire high_stage_trip_out,
	input wire [1:0] lamp_yellow,
	input wire [1:0] lamp_red,
	input wire self_fault_lamp,
	input wire supervision_relay,
	input wire disp_red_one
);
	reg [7:0] fault_run_reg;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// ==========================================
	// Consecutive fault cycles
	always @(posedge sys_clk) begin
		if (!rst_b || !internal_fault)
			fault_run_reg <= 8'h00;
		else if (fault_run_reg != 8'hff)
			fault_run_reg <= fault_run_reg + 8'h01;
	end
	// ==========================================
	// Properties
	a_low_trip_start: assert property ($rose(low_stage_trip_out) |-> $past(low_stage_start_out))
		else $error("low trip without start");
	a_high_trip_start: assert property ($rose(high_stage_trip_out) |-> $past(high_stage_start_out))
		else $error("high trip without start");
	a_red_after_trip: assert property ($rose(low_stage_trip_out) |-> ##[1:2] lamp_red[0])
		else $error("red lamp missing");
	a_yellow_on_start: assert property ($rose(low_stage_start_out) |-> ##[1:2] lamp_yellow[0])
		else $error("yellow lamp missing");
	a_lamp_not_early: assert property ($rose(self_fault_lamp) |-> fault_run_reg >= 8'h0f)
		else $error("fault lamp too early");
	a_lamp_in_time: assert property (fault_run_reg == 8'h18 |-> self_fault_lamp)
		else $error("fault lamp late");
	a_relay_with_lamp: assert property (supervision_relay == self_fault_lamp)
		else $error("relay and lamp differ");
	a_code_survives: assert property (disp_red_one && internal_fault && reset_button |=> disp_red_one)
		else $error("fault code cleared");
endmodule

bind earth_fault_stage_indication ef_stage_monitor u_mon (.sys_clk, .rst_b, .internal_fault, .reset_button,
	.low_stage_start_out, .low_stage_trip_out, .high_stage_start_out, .high_stage_trip_out,
	.lamp_yellow, .lamp_red, .self_fault_lamp, .supervision_relay, .disp_red_one);

// ===== verification/relay_wiring.sv
// Purpose: Relay assembly wiring and remote side model
// Assumes: Levels change just after a rising edge
// Notes: Driven by bench task calls
`timescale 1ns/1ns
module relay_wiring (
	// Clock
	input wire sys_clk,
	// Measurement
	output reg [7:0] level_sin,
	output reg [7:0] level_cos,
	output reg voltage_above,
	output reg direction_reverse,
	// Controls
	output reg low_stage_block,
	output reg high_stage_block,
	output reg characteristic_select,
	output reg reset_button,
	// Supervision
	output reg internal_fault,
	output reg [11:0] fault_code
);
	initial begin
		{level_sin, level_cos, voltage_above, direction_reverse} = 18'h00000;
		{low_stage_block, high_stage_block, characteristic_select, reset_button} = 4'h0;
		internal_fault = 1'b0;
		fault_code = 12'h000;
	end
	task drive(input [7:0] s, input [7:0] c, input v, input r);
		begin
			@(posedge sys_clk);
			level_sin <= s;
			level_cos <= c;
			voltage_above <= v;
			direction_reverse <= r;
		end
	endtask
	task block(input lo, input hi);
		begin
			@(posedge sys_clk);
			low_stage_block <= lo;
			high_stage_block <= hi;
		end
	endtask
	task select(input c);
		begin
			@(posedge sys_clk);
			characteristic_select <= c;
		end
	endtask
	task press;
		begin
			@(posedge sys_clk);
			reset_button <= 1'b1;
			@(posedge sys_clk);
			reset_button <= 1'b0;
		end
	endtask
	task fault(input f, input [11:0] code);
		begin
			@(posedge sys_clk);
			internal_fault <= f;
			fault_code <= code;
		end
	endtask
endmodule

// ===== verification/earth_fault_stage_indication_test.sv
// Purpose: Bench for the stage indication block
// Assumes: Short timer tick of 4 cycles
// Notes: Register access over AXI4-Lite
`timescale 1ns/1ns
`define CHK(n,e,g) begin tests_run++; if ((g)!==(e)) begin errors++; $display("mismatch %s exp %h got %h",n,e,g); end end
module earth_fault_stage_indication_test;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp, lamp_yellow, lamp_red;
	wire [31:0] s_axi_rdata;
	wire [7:0] level_sin, level_cos;
	wire [11:0] fault_code, disp_digits;
	wire [4:0] setting_leds;
	wire voltage_above, direction_reverse, low_stage_block, high_stage_block, characteristic_select;
	wire reset_button, internal_fault, low_stage_start_out, low_stage_trip_out, high_stage_start_out;
	wire high_stage_trip_out, reclose_initiate_a, reclose_initiate_b, self_fault_lamp, supervision_relay;
	wire disp_red_one, disp_red_minus;
	int errors = 0;
	int tests_run = 0;
	int cycles = 0;
	int k;
	earth_fault_stage_indication #(.TICK_CYCLES(4)) uut (.*);
	relay_wiring wiring (.*);
	always #10 sys_clk = ~sys_clk;
	// ==========================================
	// Tasks
	task results;
		begin
			$display("checks %0d errors %0d", tests_run, errors);
			if (errors == 0 && tests_run > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task wait_n(input int n);
		begin
			repeat (n) @(posedge sys_clk);
			@(negedge sys_clk);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d, input [1:0] er);
		logic ta, tw;
		begin
			ta = 1'b0;
			tw = 1'b0;
			@(posedge sys_clk);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			while (!(ta && tw)) begin
				@(negedge sys_clk);
				if (s_axi_awvalid && s_axi_awready) ta = 1'b1;
				if (s_axi_wvalid && s_axi_wready) tw = 1'b1;
				@(posedge sys_clk);
				if (ta) s_axi_awvalid <= 1'b0;
				if (tw) s_axi_wvalid <= 1'b0;
			end
			do @(negedge sys_clk); while (s_axi_bvalid !== 1'b1);
			`CHK("bresp", er, s_axi_bresp)
			@(posedge sys_clk);
			s_axi_bready <= 1'b0;
		end
	endtask
	task rd(input [7:0] a, input [31:0] e, input [1:0] er);
		begin
			@(posedge sys_clk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			do @(negedge sys_clk); while (s_axi_arready !== 1'b1);
			@(posedge sys_clk);
			s_axi_arvalid <= 1'b0;
			do @(negedge sys_clk); while (s_axi_rvalid !== 1'b1);
			`CHK("rdata", e, s_axi_rdata)
			`CHK("rresp", er, s_axi_rresp)
			@(posedge sys_clk);
			s_axi_rready <= 1'b0;
		end
	endtask
	task low_run;
		begin
			wiring.select(1'b1);
			wait_n(3);
			`CHK("low start", 1'b1, low_stage_start_out)
			`CHK("yellow", 1'b1, lamp_yellow[0])
			`CHK("reclose a", 1'b1, reclose_initiate_a)
			wait_n(8);
			`CHK("early trip", 1'b0, low_stage_trip_out)
			wait_n(13);
			`CHK("low trip", 1'b1, low_stage_trip_out)
			`CHK("red", 1'b1, lamp_red[0])
			wiring.select(1'b0);
			wait_n(4);
			`CHK("start gone", 1'b0, low_stage_start_out)
			`CHK("red gone", 1'b0, lamp_red[0])
			`CHK("yellow kept", 1'b1, lamp_yellow[0])
		end
	endtask
	// ==========================================
	// Sequence
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors++;
			results;
		end
	end
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		repeat (4) @(posedge sys_clk);
		rst_b <= 1'b1;
		rd(8'h00, 32'h00000000, 2'b00);
		rd(8'h04, 32'h00000101, 2'b00);
		rd(8'h08, 32'h00000105, 2'b00);
		rd(8'h1c, 32'h00000000, 2'b10);
		wr(8'h1c, 32'h00000001, 2'b10);
		wr(8'h00, 32'h000f0102, 2'b00);
		wr(8'h04, 32'h00000305, 2'b00);
		wr(8'h08, 32'h0000020a, 2'b00);
		wr(8'h0c, 32'h00000000, 2'b00);
		wiring.drive(8'h00, 8'h08, 1'b1, 1'b0);
		wait_n(2);
		`CHK("digits", 12'h005, disp_digits)
		`CHK("leds", 5'h01, setting_leds)
		for (k = 0; k < 3; k++) begin
			low_run;
			low_run;
			if (k == 0)
				wiring.press;
			else
				wr(8'h10, k, 2'b00);
			wait_n(3);
			`CHK("yellow clear", 1'b0, lamp_yellow[0])
		end
		wiring.block(1'b1, 1'b0);
		wiring.select(1'b1);
		wait_n(24);
		`CHK("blocked start", 1'b0, low_stage_start_out)
		`CHK("blocked trip", 1'b0, low_stage_trip_out)
		wr(8'h08, 32'h000002ff, 2'b00);
		wiring.drive(8'h00, 8'h32, 1'b1, 1'b0);
		wait_n(24);
		`CHK("inf start", 1'b0, high_stage_start_out)
		`CHK("inf trip", 1'b0, high_stage_trip_out)
		wr(8'h08, 32'h0000020a, 2'b00);
		wait_n(3);
		`CHK("high start", 1'b1, high_stage_start_out)
		`CHK("reclose b", 1'b1, reclose_initiate_b)
		`CHK("high yellow", 1'b1, lamp_yellow[1])
		wait_n(16);
		`CHK("high trip", 1'b1, high_stage_trip_out)
		`CHK("high red", 1'b1, lamp_red[1])
		wr(8'h00, 32'h000f010a, 2'b00);
		wiring.block(1'b1, 1'b1);
		wait_n(3);
		`CHK("high blocked", 1'b0, high_stage_start_out)
		`CHK("trip latched", 1'b1, high_stage_trip_out)
		wr(8'h10, 32'h00000001, 2'b00);
		wait_n(2);
		`CHK("latch cleared", 1'b0, high_stage_trip_out)
		wr(8'h00, 32'h000f0133, 2'b00);
		wr(8'h0c, 32'h00000002, 2'b00);
		wait_n(2);
		`CHK("minus", 1'b1, disp_red_minus)
		`CHK("high digits", 12'h008, disp_digits)
		wr(8'h0c, 32'h00000001, 2'b00);
		wait_n(2);
		`CHK("low time", 12'h010, disp_digits)
		`CHK("time led", 5'h02, setting_leds)
		wr(8'h0c, 32'h00000004, 2'b00);
		wait_n(2);
		`CHK("sum leds", 5'h10, setting_leds)
		`CHK("sum digits", 12'h051, disp_digits)
		wiring.fault(1'b1, 12'h123);
		wait_n(10);
		`CHK("lamp early", 1'b0, self_fault_lamp)
		wait_n(12);
		`CHK("fault lamp", 1'b1, self_fault_lamp)
		`CHK("relay", 1'b1, supervision_relay)
		`CHK("code", 12'h123, disp_digits)
		wiring.press;
		wr(8'h10, 32'h00000003, 2'b00);
		wait_n(3);
		`CHK("code kept", 12'h123, disp_digits)
		`CHK("red one", 1'b1, disp_red_one)
		results;
	end
endmodule
